// ==== common/lane_link_if.sv ====
// Link between the memory controller end and the memory device end.
// Two-way pins carry value and enable from each end; the wire level is resolved here.
`timescale 1ns/1ps
`default_nettype none
interface lane_link_if
  import lane_pkg::*;
#(
  parameter int DQ_W = 16
);
  localparam int LANES = DQ_W / BYTE_W;
  logic             ck;
  logic             cke;
  logic             cs_n;
  logic [CA_W-1:0]  command_address_bus;
  logic [LANES-1:0] write_byte_mask;
  logic [DQ_W-1:0]  c_dq;
  logic             c_dq_oe;
  logic [LANES-1:0] c_dqs;
  logic             c_dqs_oe;
  logic [DQ_W-1:0]  d_dq;
  logic             d_dq_oe;
  logic [LANES-1:0] d_dqs;
  logic             d_dqs_oe;
  logic [DQ_W-1:0]  dq;
  logic [LANES-1:0] dqs;

  // An undriven strobe settles low, which serves as the idle level between bursts.
  assign dq  = c_dq_oe ? c_dq : (d_dq_oe ? d_dq : '0);
  assign dqs = c_dqs_oe ? c_dqs : (d_dqs_oe ? d_dqs : '0);

  modport ctrl (
    output ck, cke, cs_n, command_address_bus, write_byte_mask,
    output c_dq, c_dq_oe, c_dqs, c_dqs_oe,
    input  dq, dqs
  );
  modport dev (
    input  ck, cke, cs_n, command_address_bus, write_byte_mask,
    output d_dq, d_dq_oe, d_dqs, d_dqs_oe,
    input  dq, dqs
  );
endinterface
`default_nettype wire

// ==== common/lane_pkg.sv ====
// Constants, field layouts and types shared by both ends of the data-lane link.
// Assumes one system clock of 125 MHz at both ends; the controller makes the link clock.
// How it works
// [R1] Masked write bytes never reach the memory.
// [R2] Write masks captured on both strobe edges.
// [R3] Mask bit b covers data bits 8b to 8b+7.
// [R4] Strobe b accompanies byte lane b.
// [R5] Lowest column bit never sent, taken as zero.
// [R6] Unused address positions on the bus ignored.
// [R7] One 4n word per core cycle, four beats.
// [R8] Bursts start at address, wrap sequentially.
// [R9] Idle reported only with every bank precharged.
// [R10] Clock enable low through and after ramp.
// [R11] Outputs released whenever clock enable is low.
// [R12] Clock enable rises five clocks after references.
// [R13] Four banks, thirteen rows, nine or eight columns.
// [R14] Read strobe edge-aligned, write strobe centred.
// [R15] Address on both edges, select and enable rising.
package lane_pkg;
  localparam int CA_W        = 10;
  localparam int BYTE_W      = 8;
  localparam int BANK_W      = 2;
  localparam int BANKS       = 4;
  localparam int ROW_W       = 13;
  localparam int COL_W_X16   = 9;
  localparam int COL_W_X32   = 8;
  localparam int DQ_W_X32    = 32;
  localparam int PREFETCH    = 4;
  localparam int BURST_LEN   = 4;
  localparam int RD_LAT      = 3;
  localparam int FIFO_DEPTH  = 16;
  localparam int VREF_CLOCKS = 5;
  // Link clock timing, derived from the system clock period.
  localparam int SYS_PERIOD_NS = 8;
  localparam int CK_PERIOD_NS  = 80;
  localparam int CK_HALF       = CK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int SLOT_FALL     = CK_HALF / 2;
  localparam int SLOT_RISE     = CK_HALF + CK_HALF / 2;
  // Command/address layout: rise half {hi, bank, op}, fall half upper row/column bits.
  localparam int OP_LSB    = 0;
  localparam int OP_W      = 3;
  localparam int BANK_LSB  = 3;
  localparam int HI_LSB    = 5;
  localparam int HI_W      = 5;
  localparam int ROW_HI_W  = 8;
  localparam int COL_HI_W  = 3;

  typedef enum logic [2:0] {
    OP_NOP  = 3'h0,
    OP_ACT  = 3'h1,
    OP_WR   = 3'h2,
    OP_RD   = 3'h3,
    OP_PRE  = 3'h4,
    OP_PREA = 3'h5
  } op_t;

  function automatic int col_width(input int dq_w);
    return (dq_w == DQ_W_X32) ? COL_W_X32 : COL_W_X16;
  endfunction
endpackage

// ==== logic/lane_controller.sv ====
// Memory controller end: makes the link clock, clock enable, commands and write bursts.
// Write beats queue in a FIFO; read beats come back as one-cycle strobes to the user.
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;
  logic [AW:0]      cnt_next;

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = count_o != '0;
  assign out_data_o  = mem[rd_ptr];
  assign cnt_next    = count_o + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // Ready is registered from the next count so that it never promises a slot it lacks.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count_o    <= '0;
      in_ready_o <= 1'b0;
    end
    else
    begin
      wr_ptr     <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr     <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count_o    <= cnt_next;
      in_ready_o <= cnt_next != (AW+1)'(DEPTH);
    end
  end
endmodule

module lane_controller
  import lane_pkg::*;
#(
  parameter int DQ_W  = 16,
  parameter int BURST = BURST_LEN
)(
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  lane_link_if.ctrl                  link,
  input  wire logic                  vref_ok_i,
  input  wire logic                  release_i,
  input  wire logic                  cmd_valid_i,
  output logic                       cmd_ready_o,
  input  wire op_t                   cmd_op_i,
  input  wire logic [BANK_W-1:0]     cmd_bank_i,
  input  wire logic [ROW_W-1:0]      cmd_row_i,
  input  wire logic [COL_W_X16-1:0]  cmd_col_i,
  input  wire logic                  wdata_valid_i,
  output logic                       wdata_ready_o,
  input  wire logic [DQ_W-1:0]       wdata_i,
  input  wire logic [DQ_W/BYTE_W-1:0] wmask_i,
  output logic                       rdata_valid_o,
  output logic [DQ_W-1:0]            rdata_o,
  output logic                       cke_on_o
);
  localparam int LANES = DQ_W / BYTE_W;
  localparam int PH_W  = $clog2(2 * CK_HALF);
  localparam int CNT_W = $clog2(BURST) + 1;
  localparam int VC_W  = $clog2(VREF_CLOCKS) + 1;
  localparam int FW    = DQ_W + LANES;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_WAIT = 3'h1,
    C_FALL = 3'h2,
    C_WR   = 3'h3,
    C_RD   = 3'h4
  } ctrl_state_t;

  ctrl_state_t           st_reg;
  logic [PH_W-1:0]       ph;
  logic                  slot_r;
  logic                  slot_f;
  logic                  last_ph;
  logic [VC_W-1:0]       vcnt;
  logic                  vstart;
  logic                  take;
  op_t                   op_reg;
  logic [BANK_W-1:0]     bank_reg;
  logic [ROW_W-1:0]      row_reg;
  logic [COL_W_X16-1:0]  col_reg;
  logic [CNT_W-1:0]      beat;
  logic                  pop;
  logic                  f_valid;
  logic [FW-1:0]         f_data;
  logic [$clog2(FIFO_DEPTH):0] f_count;
  logic [DQ_W-1:0]       dq_s1;
  logic [DQ_W-1:0]       dq_s2;
  logic [LANES-1:0]      dqs_s1;
  logic [LANES-1:0]      dqs_s2;
  logic [LANES-1:0]      dqs_d;
  logic [LANES-1:0]      edge_p1;
  logic [LANES-1:0]      edge_p2;

  beat_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (wdata_valid_i),
    .in_ready_o  (wdata_ready_o),
    .in_data_i   ({wmask_i, wdata_i}),
    .out_valid_o (f_valid),
    .out_ready_i (pop),
    .out_data_o  (f_data),
    .count_o     (f_count)
  );

  assign last_ph = ph == PH_W'(2 * CK_HALF - 1);
  assign slot_r  = ph == PH_W'(SLOT_RISE);
  assign slot_f  = ph == PH_W'(SLOT_FALL);
  assign take    = cmd_valid_i & cmd_ready_o;
  assign pop     = (st_reg == C_WR) && (slot_r || slot_f) && beat != CNT_W'(BURST) && f_valid;

  // [R14] Write strobe is a copy of the clock; data moves mid-half, so edges are centred.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      ph         <= '0;
      link.ck    <= 1'b1;
      link.c_dqs <= '1;
    end
    else
    begin
      ph <= last_ph ? '0 : PH_W'(ph + 1'b1);
      if (last_ph || ph == PH_W'(CK_HALF - 1))
      begin
        link.ck    <= last_ph;
        link.c_dqs <= {LANES{last_ph}};
      end
    end
  end

  // [R10] Held low from reset until references are settled.
  // [R12] Five link clocks of valid references first.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      vcnt     <= '0;
      vstart   <= 1'b0;
      link.cke <= 1'b0;
      cke_on_o <= 1'b0;
    end
    else
    begin
      if (!vref_ok_i)
      begin
        vcnt   <= '0;
        vstart <= 1'b0;
      end
      else if (last_ph)
      begin
        // The first boundary only opens the count, so a partial period never counts.
        vstart <= 1'b1;
        if (vstart && vcnt != VC_W'(VREF_CLOCKS))
          vcnt <= vcnt + 1'b1;
      end
      if (slot_r)
      begin
        // [R11] Release request drops clock enable so the device lets go of the bus.
        link.cke <= vcnt == VC_W'(VREF_CLOCKS) && !release_i;
        cke_on_o <= vcnt == VC_W'(VREF_CLOCKS) && !release_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    dq_s1   <= link.dq;
    dq_s2   <= dq_s1;
    dqs_s1  <= link.dqs;
    dqs_s2  <= dqs_s1;
    dqs_d   <= dqs_s2;
    edge_p1 <= dqs_s2 ^ dqs_d;
    edge_p2 <= edge_p1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      st_reg                   <= C_IDLE;
      cmd_ready_o              <= 1'b0;
      link.cs_n                <= 1'b1;
      link.command_address_bus <= '0;
      link.write_byte_mask     <= '0;
      link.c_dq                <= '0;
      link.c_dq_oe             <= 1'b0;
      link.c_dqs_oe            <= 1'b0;
      rdata_valid_o            <= 1'b0;
      rdata_o                  <= '0;
      beat                     <= '0;
      op_reg                   <= OP_NOP;
      bank_reg                 <= '0;
      row_reg                  <= '0;
      col_reg                  <= '0;
    end
    else
    begin
      cmd_ready_o   <= st_reg == C_IDLE && !take && cke_on_o;
      rdata_valid_o <= 1'b0;
      case (st_reg)
        C_IDLE:
        begin
          if (take)
          begin
            op_reg   <= cmd_op_i;
            bank_reg <= cmd_bank_i;
            row_reg  <= cmd_row_i;
            col_reg  <= cmd_col_i;
            st_reg   <= C_WAIT;
          end
        end
        C_WAIT:
        begin
          // A command never leaves in the slot where clock enable drops with it.
          if (slot_r && vcnt == VC_W'(VREF_CLOCKS) && !release_i &&
              (op_reg != OP_WR || f_count >= BURST))
          begin
            link.cs_n <= 1'b0;
            link.command_address_bus <= (op_reg == OP_ACT) ?
              {row_reg[HI_W-1:0], bank_reg, op_reg} :
              {col_reg[HI_W:1], bank_reg, op_reg};
            st_reg <= C_FALL;
          end
        end
        C_FALL:
        begin
          if (slot_f)
          begin
            link.cs_n <= 1'b1;
            // [R5] Column bit zero is never placed on the bus.
            link.command_address_bus <= (op_reg == OP_ACT) ?
              CA_W'(row_reg[ROW_W-1:HI_W]) :
              CA_W'(col_reg[COL_W_X16-1:HI_W+1]);
            beat   <= '0;
            st_reg <= (op_reg == OP_WR) ? C_WR : (op_reg == OP_RD) ? C_RD : C_IDLE;
          end
        end
        C_WR:
        begin
          if (slot_r || slot_f)
          begin
            if (beat == CNT_W'(BURST))
            begin
              link.c_dq_oe  <= 1'b0;
              link.c_dqs_oe <= 1'b0;
              st_reg        <= C_IDLE;
            end
            else
            begin
              // [R3] Mask lane b travels with data byte b.
              link.c_dq            <= f_data[DQ_W-1:0];
              link.write_byte_mask <= f_data[FW-1:DQ_W];
              link.c_dq_oe         <= 1'b1;
              link.c_dqs_oe        <= 1'b1;
              beat                 <= beat + 1'b1;
            end
          end
        end
        C_RD:
        begin
          // [R4] Each byte lane is taken on its own strobe, two cycles after the edge.
          for (int l = 0; l < LANES; l++)
            if (edge_p2[l])
              rdata_o[l*BYTE_W +: BYTE_W] <= dq_s2[l*BYTE_W +: BYTE_W];
          if (edge_p2[0])
          begin
            rdata_valid_o <= 1'b1;
            beat          <= beat + 1'b1;
            if (beat == CNT_W'(BURST - 1))
              st_reg <= C_IDLE;
          end
        end
        default:
        begin
          st_reg <= C_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/lane_device.sv ====
// Memory device end: decodes commands, receives strobed writes, sends strobed reads.
// Samples every link pin through two flip-flops on the system clock.
`timescale 1ns/1ps
`default_nettype none
module lane_device
  import lane_pkg::*;
#(
  parameter int DQ_W     = 16,
  parameter int BURST    = BURST_LEN,
  parameter int READ_LAT = RD_LAT,
  parameter int ROW_KEEP = 2
)(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  lane_link_if.dev         link,
  output logic             idle_o,
  output logic [BANKS-1:0] open_banks_o,
  output logic             powered_o
);
  localparam int LANES = DQ_W / BYTE_W;
  // [R13] Column width per variant.
  localparam int COL_W = col_width(DQ_W);
  localparam int PF_W  = $clog2(PREFETCH);
  localparam int CW_W  = COL_W - PF_W;
  localparam int IDX_W = BANK_W + ROW_KEEP + CW_W;
  localparam int WORDS = BURST / PREFETCH;
  localparam int CNT_W = $clog2(BURST) + 1;
  localparam int LAT_W = $clog2(READ_LAT) + 1;

  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_WR_RX  = 3'h1,
    S_WR_CMT = 3'h2,
    S_RD_FET = 3'h3,
    S_RD_WT  = 3'h4,
    S_RD_TX  = 3'h5
  } dev_state_t;

  logic [1:0]       ck_s;
  logic             ck_d;
  logic [1:0]       cke_s;
  logic [1:0]       cs_s;
  logic [CA_W-1:0]  ca_s1;
  logic [CA_W-1:0]  ca_s2;
  logic [DQ_W-1:0]  dq_s1;
  logic [DQ_W-1:0]  dq_s2;
  logic [LANES-1:0] dqs_s1;
  logic [LANES-1:0] dqs_s2;
  logic [LANES-1:0] dqs_d;
  logic [LANES-1:0] dm_s1;
  logic [LANES-1:0] dm_s2;
  logic             rise;
  logic             fall;
  logic             cke_reg;
  logic             cmd_pend;
  logic [CA_W-1:0]  ca_rise;
  logic             fire;
  op_t              op;
  logic [BANK_W-1:0] bank;

  dev_state_t        state_reg;
  logic [BANK_W-1:0] acc_bank;
  logic [ROW_W-1:0]  acc_row;
  logic [COL_W-1:0]  acc_col;
  logic [ROW_W-1:0]  row_of [BANKS];
  logic [CNT_W-1:0]  lane_cnt [LANES];
  logic [CNT_W-1:0]  word_cnt;
  logic [CNT_W-1:0]  tx_cnt;
  logic [LAT_W-1:0]  rise_cnt;
  logic              all_rx;
  logic [DQ_W-1:0]   beat_buf [BURST];
  logic [LANES-1:0]  mask_buf [BURST];
  logic [PREFETCH*DQ_W-1:0] mem [1 << IDX_W];

  // [R8] Sequential order wrapping inside the burst.
  function automatic int slot_of(input logic [COL_W-1:0] col, input int k);
    return (int'(col) + k) % BURST;
  endfunction

  function automatic logic [IDX_W-1:0] word_addr(input logic [BANK_W-1:0] bk,
                                                 input logic [ROW_W-1:0]  rw,
                                                 input logic [COL_W-1:0]  cl,
                                                 input logic [CNT_W-1:0]  w);
    int cw;
    cw = ((int'(cl) / BURST) * BURST + int'(w) * PREFETCH) / PREFETCH;
    return {bk, rw[ROW_KEEP-1:0], CW_W'(cw)};
  endfunction

  always_ff @(posedge clk_sys_i)
  begin
    ck_s   <= {ck_s[0], link.ck};
    ck_d   <= ck_s[1];
    cke_s  <= {cke_s[0], link.cke};
    cs_s   <= {cs_s[0], link.cs_n};
    ca_s1  <= link.command_address_bus;
    ca_s2  <= ca_s1;
    dq_s1  <= link.dq;
    dq_s2  <= dq_s1;
    dqs_s1 <= link.dqs;
    dqs_s2 <= dqs_s1;
    dqs_d  <= dqs_s2;
    dm_s1  <= link.write_byte_mask;
    dm_s2  <= dm_s1;
  end

  assign rise = ck_s[1] & ~ck_d;
  assign fall = ~ck_s[1] & ck_d;

  // [R15] Select and enable taken on rising edges only.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      cke_reg  <= 1'b0;
      cmd_pend <= 1'b0;
      ca_rise  <= '0;
    end
    else if (rise)
    begin
      cke_reg  <= cke_s[1];
      cmd_pend <= cke_s[1] & ~cs_s[1];
      ca_rise  <= ca_s2;
    end
    else if (fall)
    begin
      cmd_pend <= 1'b0;
    end
  end

  // [R15] Second half of the address taken on the falling edge.
  assign fire = fall & cmd_pend & cke_reg;
  assign op   = op_t'(ca_rise[OP_LSB +: OP_W]);
  assign bank = ca_rise[BANK_LSB +: BANK_W];

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      open_banks_o <= '0;
      idle_o       <= 1'b1;
      powered_o    <= 1'b0;
    end
    else
    begin
      powered_o <= cke_reg;
      // [R9] Idle only when no bank is open.
      idle_o    <= ~|open_banks_o;
      if (fire && op == OP_ACT)
      begin
        open_banks_o[bank] <= 1'b1;
        row_of[bank]       <= {ca_s2[ROW_HI_W-1:0], ca_rise[HI_LSB +: HI_W]};
      end
      else if (fire && op == OP_PRE)
      begin
        open_banks_o[bank] <= 1'b0;
      end
      else if (fire && op == OP_PREA)
      begin
        open_banks_o <= '0;
      end
    end
  end

  always_comb
  begin
    all_rx = 1'b1;
    for (int l = 0; l < LANES; l++)
      if (lane_cnt[l] != CNT_W'(BURST))
        all_rx = 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || !cke_reg)
    begin
      state_reg     <= S_IDLE;
      link.d_dq_oe  <= 1'b0;
      link.d_dqs_oe <= 1'b0;
      link.d_dq     <= '0;
      link.d_dqs    <= '0;
      word_cnt      <= '0;
      tx_cnt        <= '0;
      rise_cnt      <= '0;
      acc_bank      <= '0;
      acc_row       <= '0;
      acc_col       <= '0;
      for (int l = 0; l < LANES; l++)
        lane_cnt[l] <= '0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (fire && (op == OP_WR || op == OP_RD))
          begin
            acc_bank <= bank;
            acc_row  <= row_of[bank];
            // [R5] Lowest column bit forced to zero.
            // [R6] Column bits beyond this variant dropped.
            acc_col  <= COL_W'({ca_s2[COL_HI_W-1:0], ca_rise[HI_LSB +: HI_W], 1'b0});
            word_cnt <= '0;
            rise_cnt <= '0;
            for (int l = 0; l < LANES; l++)
              lane_cnt[l] <= '0;
            for (int k = 0; k < BURST; k++)
              mask_buf[k] <= '1;
            state_reg <= (op == OP_WR) ? S_WR_RX : S_RD_FET;
          end
        end
        S_WR_RX:
        begin
          for (int l = 0; l < LANES; l++)
          begin
            // [R4] Each lane clocked by its own strobe.
            // [R2] Both strobe edges capture data and mask.
            if (dqs_s2[l] != dqs_d[l] && lane_cnt[l] != CNT_W'(BURST))
            begin
              // [R3] Mask bit l goes with byte lane l.
              beat_buf[slot_of(acc_col, int'(lane_cnt[l]))][l*BYTE_W +: BYTE_W] <=
                dq_s2[l*BYTE_W +: BYTE_W];
              mask_buf[slot_of(acc_col, int'(lane_cnt[l]))][l] <= dm_s2[l];
              lane_cnt[l] <= lane_cnt[l] + 1'b1;
            end
          end
          if (all_rx)
            state_reg <= S_WR_CMT;
        end
        S_WR_CMT:
        begin
          word_cnt <= word_cnt + 1'b1;
          if (word_cnt == CNT_W'(WORDS - 1))
            state_reg <= S_IDLE;
        end
        S_RD_FET:
        begin
          // [R7] One whole prefetch word per system cycle.
          for (int b = 0; b < PREFETCH; b++)
            beat_buf[int'(word_cnt) * PREFETCH + b] <=
              mem[word_addr(acc_bank, acc_row, acc_col, word_cnt)][b*DQ_W +: DQ_W];
          word_cnt <= word_cnt + 1'b1;
          if (word_cnt == CNT_W'(WORDS - 1))
            state_reg <= S_RD_WT;
        end
        S_RD_WT:
        begin
          if (rise)
            rise_cnt <= rise_cnt + 1'b1;
          else if (fall && rise_cnt == LAT_W'(READ_LAT - 1))
          begin
            link.d_dq_oe  <= 1'b1;
            link.d_dqs_oe <= 1'b1;
            link.d_dqs    <= '0;
            tx_cnt        <= '0;
            state_reg     <= S_RD_TX;
          end
        end
        S_RD_TX:
        begin
          if (rise || fall)
          begin
            if (tx_cnt == CNT_W'(BURST))
            begin
              link.d_dq_oe  <= 1'b0;
              link.d_dqs_oe <= 1'b0;
              state_reg     <= S_IDLE;
            end
            else
            begin
              // [R14] Data and strobe change together on each edge.
              link.d_dq  <= beat_buf[slot_of(acc_col, int'(tx_cnt))];
              link.d_dqs <= {LANES{rise}};
              tx_cnt     <= tx_cnt + 1'b1;
            end
          end
        end
        default:
        begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // [R11] The reset branch above drops every enable while clock enable is low.
  always_ff @(posedge clk_sys_i)
  begin
    if (state_reg == S_WR_CMT)
    begin
      for (int b = 0; b < PREFETCH; b++)
        for (int l = 0; l < LANES; l++)
          // [R1] Masked bytes keep their stored value.
          if (!mask_buf[int'(word_cnt) * PREFETCH + b][l])
            mem[word_addr(acc_bank, acc_row, acc_col, word_cnt)][b*DQ_W + l*BYTE_W +: BYTE_W] <=
              beat_buf[int'(word_cnt) * PREFETCH + b][l*BYTE_W +: BYTE_W];
    end
  end
endmodule
`default_nettype wire

// ==== sim/lane_link_monitor.sv ====
// Checker on the link signals between the controller end and the device end.
// Assumes BURST 4 and an 80 ns link clock; the bench places it beside the link.
`timescale 1ns/1ps
`default_nettype none
module lane_link_monitor
  import lane_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int LN   = DQ_W / BYTE_W
)(
  input wire logic            clk_sys_i,
  input wire logic            reset_i,
  input wire logic            ck,
  input wire logic            cke,
  input wire logic            cs_n,
  input wire logic [CA_W-1:0] command_address_bus,
  input wire logic            c_dq_oe,
  input wire logic            d_dq_oe,
  input wire logic [LN-1:0]   d_dqs,
  input wire logic            d_dqs_oe
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  AST_CKE_OFF: assert property ($fell(cke) |-> ##[1:20] !d_dq_oe && !d_dqs_oe)
    else $error("device drivers on after enable fell");
  AST_NO_FIGHT: assert property (!(c_dq_oe && d_dq_oe))
    else $error("both ends drive data");
  AST_CS_SETUP: assert property ($fell(cs_n) |-> !ck)
    else $error("select fell in high phase");
  AST_CKE_SETUP: assert property ($changed(cke) |-> !ck)
    else $error("enable moved in high phase");
  AST_CA_HOLD: assert property (!cs_n && $rose(ck) |-> $stable(command_address_bus))
    else $error("address moved at rise");
  AST_WR_LEN: assert property ($rose(c_dq_oe) |-> c_dq_oe [*8] ##13 !c_dq_oe)
    else $error("write burst length wrong");
  AST_RD_PRE: assert property ($rose(d_dqs_oe) |-> d_dqs == '0 && d_dq_oe)
    else $error("read strobe preamble not low");
  AST_RD_LEN: assert property ($rose(d_dq_oe) |-> d_dq_oe [*8] ##17 d_dq_oe ##1 !d_dq_oe)
    else $error("read burst length wrong");
  cover property ($rose(c_dq_oe));
  cover property ($rose(d_dq_oe));
  cover property ($fell(cke));
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Bench joining the controller and device ends across the link interface.
// Drives the user side on the falling edge; expected data follow the write masks.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lane_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        vref_ok_i = 1'b0;
  logic        release_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic        wdata_valid_i = 1'b0;
  op_t         cmd_op_i = OP_NOP;
  logic [1:0]  wmask_i = 2'h0;
  logic [1:0]  cmd_bank_i = 2'h0;
  logic [12:0] cmd_row_i = 13'h0003;
  logic [8:0]  cmd_col_i = 9'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic        cmd_ready_o, wdata_ready_o, rdata_valid_o, cke_on_o, idle_o, powered_o;
  logic [3:0]  open_banks_o;
  int          fail_count = 0;
  int          compares = 0;
  int          n;
  lane_link_if #(.DQ_W(16)) link ();
  always #4 clk_sys_i = ~clk_sys_i;
  lane_controller #(.DQ_W(16)) i_lane_controller (.clk_sys_i, .reset_i, .link, .vref_ok_i,
    .release_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_bank_i, .cmd_row_i,
    .cmd_col_i, .wdata_valid_i, .wdata_ready_o, .wdata_i, .wmask_i, .rdata_valid_o,
    .rdata_o, .cke_on_o);
  lane_device #(.DQ_W(16)) i_lane_device (.clk_sys_i, .reset_i, .link, .idle_o,
    .open_banks_o, .powered_o);
  lane_link_monitor #(.DQ_W(16)) i_lane_link_monitor (.clk_sys_i, .reset_i, .ck(link.ck),
    .cke(link.cke), .cs_n(link.cs_n), .command_address_bus(link.command_address_bus),
    .c_dq_oe(link.c_dq_oe), .d_dq_oe(link.d_dq_oe), .d_dqs(link.d_dqs),
    .d_dqs_oe(link.d_dqs_oe));
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout_if(input int cnt);
    if (cnt >= 3000)
    begin
      fail_count++;
      $display("ERROR at %0t: wait ran out", $time);
      conclude();
    end
  endtask
  // Valid stays up between beats so back-to-back pushes never touch it twice.
  task automatic push(input logic [15:0] d, input logic [1:0] m);
    wdata_i = d;
    wmask_i = m;
    wdata_valid_i = 1'b1;
    for (n = 0; n < 3000 && wdata_ready_o !== 1'b1; n++) @(negedge clk_sys_i);
    timeout_if(n);
    @(negedge clk_sys_i);
  endtask
  // The leading edge keeps valid low for one cycle after the previous take.
  task automatic cmd(input op_t op, input logic [8:0] col);
    @(negedge clk_sys_i);
    for (n = 0; n < 3000 && cmd_ready_o !== 1'b1; n++) @(negedge clk_sys_i);
    timeout_if(n);
    cmd_op_i = op;
    cmd_col_i = col;
    cmd_valid_i = 1'b1;
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic rd(input logic [8:0] col, input logic [63:0] e);
    cmd(OP_RD, col);
    for (int b = 0; b < 4; b++)
    begin
      for (n = 0; n < 3000 && rdata_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
      timeout_if(n);
      check(rdata_o, e[63 - 16 * b -: 16]);
      @(negedge clk_sys_i);
    end
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    reset_i = 1'b0;
    vref_ok_i = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    check(16'(cke_on_o), 16'h0000);
    check(16'(link.cke), 16'h0000);
    check(16'(idle_o), 16'h0001);
    for (int i = 0; i < 16; i++) push(16'h1000 + 16'(i), 2'h0);
    wdata_valid_i = 1'b0;
    @(negedge clk_sys_i);
    check(16'(wdata_ready_o), 16'h0000);
    cmd(OP_ACT, 9'h000);
    repeat (30) @(negedge clk_sys_i);
    check(16'(open_banks_o), 16'h0001);
    check(16'(idle_o), 16'h0000);
    cmd_bank_i = 2'h2;
    cmd(OP_ACT, 9'h000);
    repeat (30) @(negedge clk_sys_i);
    check(16'(open_banks_o), 16'h0005);
    cmd(OP_PRE, 9'h000);
    cmd_bank_i = 2'h0;
    repeat (30) @(negedge clk_sys_i);
    check(16'(open_banks_o), 16'h0001);
    for (int i = 0; i < 4; i++) cmd(OP_WR, 9'(4 * i));
    for (int i = 0; i < 4; i++) push(16'hFFFF, 2'(i));
    wdata_valid_i = 1'b0;
    cmd(OP_WR, 9'h005);
    rd(9'h006, {16'h10FF, 16'h1007, 16'hFFFF, 16'hFF05});
    rd(9'h001, {16'h1000, 16'h1001, 16'h1002, 16'h1003});
    cmd(OP_PREA, 9'h000);
    repeat (30) @(negedge clk_sys_i);
    check(16'(idle_o), 16'h0001);
    cmd(OP_RD, 9'h000);
    release_i = 1'b1;
    repeat (60) @(negedge clk_sys_i);
    check(16'(cke_on_o), 16'h0000);
    check(16'(powered_o), 16'h0000);
    check(link.dq, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
